// >>> common/lce_pkg.sv
//==============================================================
// Contract
// - With cycle source select at one, each rising edge of the external cycle input bumps the cycle count and zeroes the offset.
// - With cycle source select at zero, the cycle count bumps only when the offset wraps from its maximum.
// - The cycle offset advances only while the cycle timer run bit is one, otherwise it holds unless an external edge with cycle source select at one zeroes it.
// - The transmitter idle flag reads one exactly when the link transmitter is idle and ready.
// - The root bit shows whether this node is bus root and is refreshed when self-identification ends.
// - The next busy type bit reads zero for busy A and one for busy B, meaningful only in dual-phase retry.
// - A read-only field keeps the last acknowledge code received for an asynchronous transmit queue packet.
// - An event register at offset 0x008 holds the flags and an enable register of the same layout qualifies them.
// - Writing one to a set event bit acknowledges it and clears it to zero.
// - Writing one to an event bit that is already zero changes nothing.
// - With cycle master enabled, node root and a cycle count increment, a cycle-start packet is requested.
// - A cycle timeout clears cycle master enable; software restarts it by writing zero and then one.
package lce_pkg;
  //==============================================================
  // Register map (byte addresses on the host port)
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_ACK = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_EVT = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_EVTEN = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_CYTIMER = 8'h10;
  //==============================================================
  // Control register fields
  localparam int CTRL_MASTER_BIT = 11;
  localparam int CTRL_SRC_BIT = 10;
  localparam int CTRL_RUN_BIT = 9;
  localparam int CTRL_TXIDLE_BIT = 6;
  localparam int CTRL_ROOT_BIT = 5;
  localparam int CTRL_BUSY_BIT = 4;
  localparam logic [31:0] CTRL_WR_MASK = 32'h0000_0E00;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  //==============================================================
  // Acknowledge status and event fields
  localparam int ACK_LSB = 27;
  localparam int ACK_W = 4;
  localparam logic [ACK_W-1:0] ACK_RESET = 4'h0;
  localparam int EVT_CYCLE_TIMEOUT_EVENT_BIT = 5;
  localparam logic [31:0] EVT_RESET = 32'h0000_0000;
  localparam logic [31:0] EVTEN_RESET = 32'h0000_0000;
  //==============================================================
  // Cycle timer
  localparam int CYC_OFFSET_W = 12;
  localparam int CYC_COUNT_W = 13;
  localparam int CYC_COUNT_LSB = 12;
  localparam logic [CYC_OFFSET_W-1:0] CYC_OFFSET_MAX = 12'hBFF;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int OFFSET_TICK_PS = 40690;
  localparam int OFFSET_TICK_CYCLES = OFFSET_TICK_PS / CLK_PERIOD_PS;
endpackage

// >>> src/lce_cycle_timer.sv
`timescale 1ns/1ps
module lce_cycle_timer
  import lce_pkg::*;
#(
  parameter int TICK_CYCLES = OFFSET_TICK_CYCLES
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic cycleSource,
  input wire logic cycleTimerRun,
  input wire logic externalCycleIn,
  output logic countInc,
  output logic [CYC_OFFSET_W-1:0] cycleOffset,
  output logic [CYC_COUNT_W-1:0] cycleCount
);
  //==============================================================
  // Pin synchroniser and edge detect
  logic sync1_reg, sync2_reg, sync3_reg;
  logic extRise;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
    end else begin
      sync1_reg <= externalCycleIn;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end
  assign extRise = sync2_reg & ~sync3_reg;

  //==============================================================
  // Offset rate divider and counters
  logic [15:0] div_reg, div_next;
  logic tick;
  logic [CYC_OFFSET_W-1:0] off_reg, off_next;
  logic [CYC_COUNT_W-1:0] cnt_reg, cnt_next;
  logic inc_reg, inc_next;

  assign tick = (div_reg == 16'(TICK_CYCLES - 1));

  always_comb begin
    div_next = tick ? 16'h0000 : div_reg + 16'h0001;
    off_next = off_reg;
    cnt_next = cnt_reg;
    inc_next = 1'b0;
    if (cycleSource && extRise) begin
      off_next = '0;
      cnt_next = cnt_reg + 1'b1;
      inc_next = 1'b1;
    end else if (cycleTimerRun && tick) begin
      if (off_reg == CYC_OFFSET_MAX) begin
        off_next = '0;
        if (!cycleSource) begin
          cnt_next = cnt_reg + 1'b1;
          inc_next = 1'b1;
        end
      end else begin
        off_next = off_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      div_reg <= 16'h0000;
      off_reg <= '0;
      cnt_reg <= '0;
      inc_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      off_reg <= off_next;
      cnt_reg <= cnt_next;
      inc_reg <= inc_next;
    end
  end

  assign countInc = inc_reg;
  assign cycleOffset = off_reg;
  assign cycleCount = cnt_reg;

  //==============================================================
  // Checks
  property p_ext_edge;
    @(posedge clk_sys) disable iff (!nrst)
    (cycleSource && extRise) |=> (off_reg == '0) && (cnt_reg == $past(cnt_reg) + 1'b1);
  endproperty
  a_ext_edge: assert property (p_ext_edge) else $error("external edge did not step count");

  property p_wrap_step;
    @(posedge clk_sys) disable iff (!nrst)
    (!cycleSource && cycleTimerRun && tick && off_reg == CYC_OFFSET_MAX)
      |=> (cnt_reg == $past(cnt_reg) + 1'b1) ##0 countInc;
  endproperty
  a_wrap_step: assert property (p_wrap_step) else $error("wrap did not step count");

  property p_no_mid_step;
    @(posedge clk_sys) disable iff (!nrst)
    (!cycleSource && off_reg != CYC_OFFSET_MAX) |=> $stable(cnt_reg);
  endproperty
  a_no_mid_step: assert property (p_no_mid_step) else $error("count stepped without wrap");

  property p_hold_offset;
    @(posedge clk_sys) disable iff (!nrst)
    (!cycleTimerRun && !(cycleSource && extRise)) |=> $stable(off_reg);
  endproperty
  a_hold_offset: assert property (p_hold_offset) else $error("offset moved while stopped");
endmodule

// >>> src/lce_link_regs.sv
`timescale 1ns/1ps
module lce_link_regs
  import lce_pkg::*;
#(
  parameter int TICK_CYCLES = OFFSET_TICK_CYCLES
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] hostAddr,
  input wire logic [7:0] hostWrData,
  input wire logic hostWr_n,
  input wire logic hostRd_n,
  output logic [7:0] hostRdData,
  output logic hostRdEn,
  input wire logic externalCycleIn,
  input wire logic transmitterIdle,
  input wire logic rootIn,
  input wire logic selfIdDone,
  input wire logic nextBusyB,
  input wire logic [ACK_W-1:0] ackCode,
  input wire logic ackValid,
  input wire logic [31:0] eventSet,
  output logic cycleStartReq,
  output logic irq
);
  //==============================================================
  // Host port synchronisers
  logic [ADDR_W-1:0] addr1_reg, addr2_reg;
  logic [7:0] data1_reg, data2_reg;
  logic wr1_reg, wr2_reg, wr3_reg, rd1_reg, rd2_reg, rd3_reg;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      addr1_reg <= '0;
      addr2_reg <= '0;
      data1_reg <= 8'h00;
      data2_reg <= 8'h00;
      wr1_reg <= 1'b0;
      wr2_reg <= 1'b0;
      wr3_reg <= 1'b0;
      rd1_reg <= 1'b0;
      rd2_reg <= 1'b0;
      rd3_reg <= 1'b0;
    end else begin
      addr1_reg <= hostAddr;
      addr2_reg <= addr1_reg;
      data1_reg <= hostWrData;
      data2_reg <= data1_reg;
      wr1_reg <= ~hostWr_n;
      wr2_reg <= wr1_reg;
      wr3_reg <= wr2_reg;
      rd1_reg <= ~hostRd_n;
      rd2_reg <= rd1_reg;
      rd3_reg <= rd2_reg;
    end
  end

  // Strobes act once, on the synchronised leading edge
  logic wrStb, rdStb;
  logic [31:0] laneMask, wrWord;
  assign wrStb = wr2_reg & ~wr3_reg;
  assign rdStb = rd2_reg & ~rd3_reg;
  assign laneMask = 32'h0000_00FF << {addr2_reg[1:0], 3'b000};
  assign wrWord = {4{data2_reg}};

  function automatic logic hitWord(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    hitWord = ({a[ADDR_W-1:2], 2'b00} == off);
  endfunction

  //==============================================================
  // Cycle timer
  logic countInc;
  logic [CYC_OFFSET_W-1:0] cycleOffset;
  logic [CYC_COUNT_W-1:0] cycleCount;
  logic [31:0] ctrl_reg, ctrl_next;

  lce_cycle_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .cycleSource(ctrl_reg[CTRL_SRC_BIT]),
    .cycleTimerRun(ctrl_reg[CTRL_RUN_BIT]),
    .externalCycleIn(externalCycleIn),
    .countInc(countInc),
    .cycleOffset(cycleOffset),
    .cycleCount(cycleCount)
  );

  //==============================================================
  // Registers
  logic root_reg, root_next;
  logic [ACK_W-1:0] ack_reg, ack_next;
  logic [31:0] evt_reg, evt_next, en_reg, en_next;
  logic start_reg, start_next;
  logic [7:0] rdData_reg, rdData_next;
  logic [31:0] ctrlView, rdWord;

  always_comb begin
    ctrlView = ctrl_reg;
    ctrlView[CTRL_TXIDLE_BIT] = transmitterIdle;
    ctrlView[CTRL_ROOT_BIT] = root_reg;
    ctrlView[CTRL_BUSY_BIT] = nextBusyB;
  end

  always_comb begin
    ctrl_next = ctrl_reg;
    root_next = selfIdDone ? rootIn : root_reg;
    ack_next = ackValid ? ackCode : ack_reg;
    evt_next = evt_reg;
    en_next = en_reg;
    if (wrStb) begin
      if (hitWord(addr2_reg, OFF_CTRL)) begin
        ctrl_next = (ctrl_reg & ~(laneMask & CTRL_WR_MASK)) | (wrWord & laneMask & CTRL_WR_MASK);
      end else if (hitWord(addr2_reg, OFF_EVT)) begin
        // Ones clear, zeros leave the bit alone
        evt_next = evt_reg & ~(wrWord & laneMask);
      end else if (hitWord(addr2_reg, OFF_EVTEN)) begin
        en_next = (en_reg & ~laneMask) | (wrWord & laneMask);
      end
    end
    // Hardware set wins over a same-cycle acknowledge
    evt_next = evt_next | eventSet;
    if (eventSet[EVT_CYCLE_TIMEOUT_EVENT_BIT]) begin
      ctrl_next[CTRL_MASTER_BIT] = 1'b0;
    end
    start_next = countInc && ctrl_reg[CTRL_MASTER_BIT] && root_reg;
  end

  always_comb begin
    rdWord = 32'h0000_0000;
    if (hitWord(addr2_reg, OFF_CTRL)) begin
      rdWord = ctrlView;
    end else if (hitWord(addr2_reg, OFF_ACK)) begin
      rdWord[ACK_LSB +: ACK_W] = ack_reg;
    end else if (hitWord(addr2_reg, OFF_EVT)) begin
      rdWord = evt_reg;
    end else if (hitWord(addr2_reg, OFF_EVTEN)) begin
      rdWord = en_reg;
    end else if (hitWord(addr2_reg, OFF_CYTIMER)) begin
      rdWord[CYC_COUNT_LSB +: CYC_COUNT_W] = cycleCount;
      rdWord[CYC_OFFSET_W-1:0] = cycleOffset;
    end
    rdData_next = rdStb ? 8'(rdWord >> {addr2_reg[1:0], 3'b000}) : rdData_reg;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg <= CTRL_RESET;
      root_reg <= 1'b0;
      ack_reg <= ACK_RESET;
      evt_reg <= EVT_RESET;
      en_reg <= EVTEN_RESET;
      start_reg <= 1'b0;
      rdData_reg <= 8'h00;
    end else begin
      ctrl_reg <= ctrl_next;
      root_reg <= root_next;
      ack_reg <= ack_next;
      evt_reg <= evt_next;
      en_reg <= en_next;
      start_reg <= start_next;
      rdData_reg <= rdData_next;
    end
  end

  assign hostRdData = rdData_reg;
  assign hostRdEn = rd2_reg & rd3_reg;
  assign cycleStartReq = start_reg;
  assign irq = |(evt_reg & en_reg);

  //==============================================================
  // Checks
  property p_txidle_read;
    @(posedge clk_sys) disable iff (!nrst)
    (rdStb && addr2_reg == OFF_CTRL) |=> hostRdData[CTRL_TXIDLE_BIT] == $past(transmitterIdle);
  endproperty
  a_txidle_read: assert property (p_txidle_read) else $error("idle flag misread");

  property p_root_update;
    @(posedge clk_sys) disable iff (!nrst)
    selfIdDone |=> (root_reg == $past(rootIn)) ##1 (root_reg == $past(rootIn, 2) || $past(selfIdDone));
  endproperty
  a_root_update: assert property (p_root_update) else $error("root not refreshed");

  property p_busy_read;
    @(posedge clk_sys) disable iff (!nrst)
    (rdStb && addr2_reg == OFF_CTRL) |=> hostRdData[CTRL_BUSY_BIT] == $past(nextBusyB);
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("busy type misread");

  property p_ack_capture;
    @(posedge clk_sys) disable iff (!nrst)
    ackValid |=> ack_reg == $past(ackCode);
  endproperty
  a_ack_capture: assert property (p_ack_capture) else $error("ack code not captured");

  property p_evt_clear;
    @(posedge clk_sys) disable iff (!nrst)
    (wrStb && addr2_reg == OFF_EVT && eventSet[7:0] == 8'h00)
      |=> (evt_reg[7:0] & $past(data2_reg)) == 8'h00;
  endproperty
  a_evt_clear: assert property (p_evt_clear) else $error("acknowledge did not clear");

  property p_evt_no_spurious;
    @(posedge clk_sys) disable iff (!nrst)
    1'b1 |=> (evt_reg & ~$past(evt_reg) & ~$past(eventSet)) == 32'h0000_0000;
  endproperty
  a_evt_no_spurious: assert property (p_evt_no_spurious) else $error("event set by software");

  property p_set_wins;
    @(posedge clk_sys) disable iff (!nrst)
    eventSet[0] |=> evt_reg[0];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost");

  property p_start;
    @(posedge clk_sys) disable iff (!nrst)
    (countInc && ctrl_reg[CTRL_MASTER_BIT] && root_reg) |=> cycleStartReq ##1 !cycleStartReq[*1];
  endproperty
  a_start: assert property (p_start) else $error("cycle start missing");

  property p_timeout_stop;
    @(posedge clk_sys) disable iff (!nrst)
    eventSet[EVT_CYCLE_TIMEOUT_EVENT_BIT] |=> !ctrl_reg[CTRL_MASTER_BIT] ##0 evt_reg[EVT_CYCLE_TIMEOUT_EVENT_BIT];
  endproperty
  a_timeout_stop: assert property (p_timeout_stop) else $error("master not stopped");

  property p_irq;
    @(posedge clk_sys) disable iff (!nrst)
    (|(eventSet & en_next)) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");
endmodule

// >>> sim/lce_host_model.sv
`timescale 1ns/1ps
module lce_host_model
  import lce_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [7:0] hostRdData,
  input wire logic hostRdEn,
  output logic [ADDR_W-1:0] hostAddr,
  output logic [7:0] hostWrData,
  output logic hostWr_n,
  output logic hostRd_n
);
  //==============================================================
  // Byte-wide host cycles, every change at the falling edge
  initial begin
    hostAddr = 8'h00;
    hostWrData = 8'h00;
    hostWr_n = 1'b1;
    hostRd_n = 1'b1;
  end

  // Address and data pass a two-flop synchroniser, so they settle early
  task automatic setup(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    hostAddr = a;
    hostWrData = d;
    repeat (3) @(negedge clk_sys);
  endtask

  // Once the hold has run out the lines no longer show the old value
  task automatic finish_cycle();
    repeat (4) @(negedge clk_sys);
    hostAddr = ~hostAddr;
    hostWrData = ~hostWrData;
  endtask

  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    setup(a, d);
    hostWr_n = 1'b0;
    repeat (4) @(negedge clk_sys);
    hostWr_n = 1'b1;
    finish_cycle();
  endtask

  task automatic rd8(input logic [7:0] a, output logic [7:0] d);
    d = 8'hXX;
    setup(a, hostWrData);
    hostRd_n = 1'b0;
    for (int n = 0; n < 20; n++) begin
      @(negedge clk_sys);
      if (hostRdEn === 1'b1) begin
        d = hostRdData;
        break;
      end
    end
    hostRd_n = 1'b1;
    finish_cycle();
  endtask
endmodule

// >>> sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  import lce_pkg::*;
  localparam int LIMIT = 30000;
  localparam logic [7:0] OFFS [6] = '{OFF_CTRL, OFF_ACK, OFF_EVT, OFF_EVTEN, OFF_CYTIMER, 8'h20};
  logic clk_sys, nrst, hostWr_n, hostRd_n, hostRdEn, irq, cycleStartReq;
  logic [ADDR_W-1:0] hostAddr;
  logic [7:0] hostWrData, hostRdData;
  logic externalCycleIn, transmitterIdle, rootIn, selfIdDone, nextBusyB, ackValid;
  logic [ACK_W-1:0] ackCode;
  logic [31:0] eventSet;
  int fail_count = 0;
  int checks = 0;
  int cycles = 0;
  int reqCount = 0;

  lce_link_regs #(.TICK_CYCLES(2)) i_dut (.clk_sys(clk_sys), .nrst(nrst),
    .hostAddr(hostAddr), .hostWrData(hostWrData), .hostWr_n(hostWr_n),
    .hostRd_n(hostRd_n), .hostRdData(hostRdData), .hostRdEn(hostRdEn),
    .externalCycleIn(externalCycleIn), .transmitterIdle(transmitterIdle),
    .rootIn(rootIn), .selfIdDone(selfIdDone), .nextBusyB(nextBusyB),
    .ackCode(ackCode), .ackValid(ackValid), .eventSet(eventSet),
    .cycleStartReq(cycleStartReq), .irq(irq));
  lce_host_model i_host (.clk_sys(clk_sys), .hostRdData(hostRdData), .hostRdEn(hostRdEn),
    .hostAddr(hostAddr), .hostWrData(hostWrData), .hostWr_n(hostWr_n), .hostRd_n(hostRd_n));

  //==============================================================
  // Clock, cycle counter and hang guard
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // Request pulse counted mid-cycle, where it has settled
  always @(negedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycleStartReq === 1'b1) reqCount <= reqCount + 1;
  end
  initial begin
    wait (cycles >= LIMIT);
    fail_count++;
    $display("ERROR timeout expected done seen running");
    results();
  end

  //==============================================================
  // Expectations and helpers
  function automatic logic [31:0] ctrlWord(logic ms, logic sr, logic rn, logic tx, logic rt,
                                           logic bz);
    return {20'h0, ms, sr, rn, 2'b00, tx, rt, bz, 4'h0};
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd32(input logic [7:0] a, output logic [31:0] v);
    logic [7:0] b;
    for (int i = 0; i < 4; i++) begin
      i_host.rd8(a + 8'(i), b);
      v[8*i +: 8] = b;
    end
  endtask
  task automatic wr32(input logic [7:0] a, input logic [31:0] v);
    for (int i = 0; i < 4; i++) i_host.wr8(a + 8'(i), v[8*i +: 8]);
  endtask
  task automatic setEvents(input logic [31:0] e);
    @(negedge clk_sys);
    eventSet = e;
    @(negedge clk_sys);
    eventSet = 32'h0;
  endtask
  task automatic extEdge();
    externalCycleIn = 1'b1;
    repeat (10) @(negedge clk_sys);
    externalCycleIn = 1'b0;
    repeat (10) @(negedge clk_sys);
  endtask
  task automatic results();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  //==============================================================
  // Main sequence
  initial begin
    logic [31:0] v, e, m, en, held;
    logic [ACK_W-1:0] ac;
    logic tx, bz, rootExp;
    int r0;
    {nrst, externalCycleIn, transmitterIdle, rootIn, selfIdDone, nextBusyB} = 6'b0;
    {ackValid, ackCode, eventSet} = '0;
    r0 = $urandom(41828);
    repeat (8) @(negedge clk_sys);
    nrst = 1'b1;
    // Writes to read-only and unmapped places must leave every register at reset
    foreach (OFFS[i]) if (OFFS[i] != OFF_EVTEN) wr32(OFFS[i], 32'hFFFF_F1FF);
    foreach (OFFS[i]) begin
      rd32(OFFS[i], v);
      chk("reset or read-only", 32'h0, v);
    end
    rootExp = 1'b0;
    for (int i = 0; i < 6; i++) begin
      tx = 1'($urandom);
      bz = 1'($urandom);
      transmitterIdle = tx;
      nextBusyB = bz;
      rootIn = 1'($urandom);
      // Root only follows the input at the end of self-identification
      if (i % 2 == 1) begin
        rootExp = rootIn;
        setEvents(32'h0);
        selfIdDone = 1'b1;
        @(negedge clk_sys);
        selfIdDone = 1'b0;
      end
      rd32(OFF_CTRL, v);
      chk("ctrl status", ctrlWord(1'b0, 1'b0, 1'b0, tx, rootExp, bz), v);
    end
    for (int i = 0; i < 2; i++) begin
      ac = ACK_W'($urandom);
      ackCode = ac;
      ackValid = 1'b1;
      @(negedge clk_sys);
      ackValid = 1'b0;
      ackCode = ~ac;
      rd32(OFF_ACK, v);
      chk("ack code", {1'b0, ac, 27'h0}, v);
    end
    e = $urandom | 32'h1;
    setEvents(e);
    rd32(OFF_EVT, v);
    chk("event flags", e, v);
    m = $urandom & ~32'h1;
    wr32(OFF_EVT, m);
    rd32(OFF_EVT, v);
    chk("event ack", e & ~m, v);
    en = $urandom & ~(e & ~m);
    wr32(OFF_EVTEN, en);
    rd32(OFF_EVTEN, v);
    chk("enable", en, v);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr32(OFF_EVTEN, e & ~m);
    chk("irq raised", 32'h1, {31'h0, irq});
    wr32(OFF_EVT, 32'hFFFF_FFFF);
    rd32(OFF_EVT, v);
    chk("event cleared", 32'h0, v);
    chk("irq cleared", 32'h0, {31'h0, irq});
    // Free-running timer across one offset wrap, master disabled
    i_host.wr8(OFF_CTRL + 8'h01, 8'h02);
    repeat (6300) @(negedge clk_sys);
    i_host.wr8(OFF_CTRL + 8'h01, 8'h00);
    rd32(OFF_CYTIMER, v);
    chk("count at wrap", 32'h1, {19'h0, v[24:12]});
    chk("offset past wrap", 32'h1, {31'h0, v[11:0] < 12'h200 && v[11:0] != 12'h0});
    chk("no start without master", 32'h0, 32'(reqCount));
    held = v;
    repeat (50) @(negedge clk_sys);
    rd32(OFF_CYTIMER, v);
    chk("offset held", held, v);
    // External cycle source as root cycle master
    rootIn = 1'b1;
    selfIdDone = 1'b1;
    @(negedge clk_sys);
    selfIdDone = 1'b0;
    i_host.wr8(OFF_CTRL + 8'h01, 8'h0C);
    r0 = reqCount;
    repeat (3) extEdge();
    rd32(OFF_CYTIMER, v);
    chk("external count", {7'h0, 13'h4, 12'h0}, v);
    chk("start requests", 32'h3, 32'(reqCount - r0));
    setEvents(32'h20);
    rd32(OFF_CTRL, v);
    chk("master off", ctrlWord(1'b0, 1'b1, 1'b0, tx, 1'b1, bz), v);
    extEdge();
    chk("no start", 32'h3, 32'(reqCount - r0));
    i_host.wr8(OFF_CTRL + 8'h01, 8'h04);
    i_host.wr8(OFF_CTRL + 8'h01, 8'h0C);
    extEdge();
    chk("restarted", 32'h4, 32'(reqCount - r0));
    results();
  end
endmodule
